/* File: design/timer_pkg.sv */
// Package with register map, field layout, reset values and carrier types
package timer_pkg;

   // ---------------------------------------------------------------
   // Register offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] OFS_IRQ_CONTROL   = 8'h0B;
   localparam logic [7:0] OFS_IRQ_FLAGS     = 8'h0C;
   localparam logic [7:0] OFS_COUNT_LOW     = 8'h0E;
   localparam logic [7:0] OFS_COUNT_HIGH    = 8'h0F;
   localparam logic [7:0] OFS_TIMER_CONTROL = 8'h10;
   localparam logic [7:0] OFS_CAPTURE_LOW   = 8'h15;
   localparam logic [7:0] OFS_CAPTURE_HIGH  = 8'h16;
   localparam logic [7:0] OFS_CAPTURE_MODE  = 8'h17;
   localparam logic [7:0] OFS_PORT_DATA     = 8'h07;
   localparam logic [7:0] OFS_PORT_DIR      = 8'h87;
   localparam logic [7:0] OFS_IRQ_ENABLE    = 8'h8C;

   // ---------------------------------------------------------------
   // Field positions and masks
   // ---------------------------------------------------------------
   localparam int         BIT_OVERFLOW     = 0;
   localparam int         BIT_CAPTURE      = 2;
   localparam int         BIT_GLOBAL_EN    = 6;
   localparam logic [7:0] IRQ_BITS_MASK    = 8'h4F;
   localparam logic [7:0] TCON_MASK        = 8'h3F;
   localparam logic [7:0] CAPCTL_MASK      = 8'h0F;
   localparam logic [7:0] PORT_MASK        = 8'h07;
   localparam int         PIN_EXT_CLOCK    = 0;
   localparam int         PIN_OSC_INPUT    = 1;

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [7:0]  RST_ZERO_BYTE   = 8'h00;
   localparam logic [2:0]  RST_PORT_DIR    = 3'h7;
   localparam logic [15:0] RST_COUNT       = 16'h0000;
   localparam logic [15:0] COUNT_ALL_ONES  = 16'hFFFF;

   // ---------------------------------------------------------------
   // Capture unit mode codes and timing
   // ---------------------------------------------------------------
   localparam logic [3:0] MODE_OFF         = 4'h0;
   localparam logic [3:0] MODE_FALL        = 4'h4;
   localparam logic [3:0] MODE_RISE        = 4'h5;
   localparam logic [3:0] MODE_RISE4       = 4'h6;
   localparam logic [3:0] MODE_RISE16      = 4'h7;
   localparam logic [3:0] MODE_TRIGGER     = 4'hB;
   localparam logic [1:0] INSTR_LAST       = 2'h3;

   // Timer control layout, bit 0 in the last field
   typedef struct packed {
      logic [1:0] unused;
      logic [1:0] prescale_sel;
      logic       low_power_osc_enable;
      logic       ext_sync_bypass;
      logic       clock_source_sel;
      logic       counter_run;
   } timer_ctrl_t;

   // Register port request
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } reg_req_t;

endpackage : timer_pkg

/* File: design/capture_event_unit.sv */
// Capture pin edge detector with every-Nth-edge prescaler
`timescale 1ns/1ps
module capture_event_unit (
   input  wire logic       clock,
   input  wire logic       reset_n,
   input  wire logic       pin_level,
   input  wire logic [3:0] mode,
   output logic            event_pulse,
   output logic            in_capture
);

   logic       pin_prev_r;
   logic [3:0] edge_cnt_r;
   logic       rise;
   logic       fall;

   // ---------------------------------------------------------------
   // Edge detection
   // ---------------------------------------------------------------
   // The pin level is watched whatever its direction
   assign rise = ~pin_prev_r & pin_level;
   assign fall = pin_prev_r & ~pin_level;
   assign in_capture = (mode[3:2] == 2'h1);

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         pin_prev_r <= 1'b0;
      end else begin
         pin_prev_r <= pin_level;
      end
   end

   // Edge counter; a change between capture settings keeps its count
   always_ff @(posedge clock) begin
      if (!reset_n || !in_capture) begin
         edge_cnt_r <= 4'h0;
      end else if (rise) begin
         edge_cnt_r <= 4'(edge_cnt_r + 4'h1);
      end
   end

   // Event selection
   always_comb begin
      case (mode)
         timer_pkg::MODE_FALL:   event_pulse = fall;
         timer_pkg::MODE_RISE:   event_pulse = rise;
         timer_pkg::MODE_RISE4:  event_pulse = rise && (edge_cnt_r[1:0] == 2'h3);
         timer_pkg::MODE_RISE16: event_pulse = rise && (edge_cnt_r == 4'hF);
         default:                event_pulse = 1'b0;
      endcase
   end

   property p_prescaler_idle;
      @(posedge clock) disable iff (!reset_n)
      !in_capture |=> (edge_cnt_r == 4'h0) || in_capture;
   endproperty
   a_prescaler_idle: assert property (p_prescaler_idle)
      else $error("Edge counter not cleared outside capture");

endmodule : capture_event_unit

/* File: design/timer16_with_capture.sv */
// 16-bit timer/counter with capture unit and peripheral interrupt enables
`timescale 1ns/1ps
module timer16_with_capture (
   input  wire logic       clock,
   input  wire logic       reset_n,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   output logic            irq_request,
   input  wire logic       ext_clock_in,
   input  wire logic       capture_pin_in,
   output logic      [2:0] port_out,
   output logic      [2:0] port_oe,
   output logic            low_power_osc_enable
);

   timer_pkg::reg_req_t    req;
   timer_pkg::timer_ctrl_t tcon_r;
   logic [15:0] counter_value_r;
   logic [15:0] capture_register_r;
   logic [7:0]  flags_r;
   logic [7:0]  enables_r;
   logic [7:0]  irq_control_r;
   logic [3:0]  capture_event_sel_r;
   logic [2:0]  port_data_r;
   logic [2:0]  port_c_direction_r;
   logic [7:0]  rdata_nxt;
   logic [1:0]  instr_div_r;
   logic [2:0]  pre_cnt_r;
   logic        sync1_r;
   logic        sync2_r;
   logic        sync_prev_r;
   logic        raw_prev_r;
   logic        instr_tick;
   logic        sync_edge;
   logic        raw_edge;
   logic        src_tick;
   logic        count_tick;
   logic        wr_low;
   logic        wr_high;
   logic        trigger;
   logic        wrap;
   logic        cap_event;
   logic        in_capture;
   logic        flags_wr;

   assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   // Last prescaler count before a counter tick
   function automatic logic [2:0] prescale_last(input logic [1:0] sel);
      case (sel)
         2'h3:    prescale_last = 3'h7;
         2'h2:    prescale_last = 3'h3;
         2'h1:    prescale_last = 3'h1;
         default: prescale_last = 3'h0;
      endcase
   endfunction : prescale_last

   function automatic logic hit(input logic [7:0] ofs);
      hit = req.wr && (req.addr == ofs);
   endfunction : hit

   // ---------------------------------------------------------------
   // Clock sources
   // ---------------------------------------------------------------
   // Instruction cycle is one clock in four
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         instr_div_r <= 2'h0;
      end else begin
         instr_div_r <= 2'(instr_div_r + 2'h1);
      end
   end

   // Two-flop synchroniser plus a raw edge path for bypass mode
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         sync1_r     <= 1'b0;
         sync2_r     <= 1'b0;
         sync_prev_r <= 1'b0;
         raw_prev_r  <= 1'b0;
      end else begin
         sync1_r     <= ext_clock_in;
         sync2_r     <= sync1_r;
         sync_prev_r <= sync2_r;
         raw_prev_r  <= ext_clock_in;
      end
   end

   assign instr_tick = (instr_div_r == timer_pkg::INSTR_LAST);
   assign sync_edge  = sync2_r & ~sync_prev_r;
   // Bypass is two cycles quicker but capture timing is not guaranteed
   assign raw_edge   = ext_clock_in & ~raw_prev_r;
   assign src_tick   = tcon_r.clock_source_sel
                       ? (tcon_r.ext_sync_bypass ? raw_edge : sync_edge)
                       : instr_tick;

   // Prescaler only advances while the counter runs
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         pre_cnt_r <= 3'h0;
      end else if (src_tick && tcon_r.counter_run) begin
         if (pre_cnt_r >= prescale_last(tcon_r.prescale_sel)) begin
            pre_cnt_r <= 3'h0;
         end else begin
            pre_cnt_r <= 3'(pre_cnt_r + 3'h1);
         end
      end
   end

   assign count_tick = src_tick && tcon_r.counter_run
                       && (pre_cnt_r >= prescale_last(tcon_r.prescale_sel));

   // ---------------------------------------------------------------
   // Counter
   // ---------------------------------------------------------------
   assign wr_low  = req.wr && (req.addr == timer_pkg::OFS_COUNT_LOW);  // Nets must see req
   assign wr_high = req.wr && (req.addr == timer_pkg::OFS_COUNT_HIGH);
   assign trigger = (capture_event_sel_r == timer_pkg::MODE_TRIGGER)
                    && (counter_value_r == capture_register_r);
   assign wrap    = count_tick && !wr_low && !wr_high && !trigger
                    && (counter_value_r == timer_pkg::COUNT_ALL_ONES);

   // Software write wins, then trigger clear, then counting
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         counter_value_r <= timer_pkg::RST_COUNT;
      end else if (wr_low || wr_high) begin
         if (wr_low) begin
            counter_value_r[7:0] <= req.wdata;
         end
         if (wr_high) begin
            counter_value_r[15:8] <= req.wdata;
         end
      end else if (trigger) begin
         counter_value_r <= timer_pkg::RST_COUNT;
      end else if (count_tick) begin
         counter_value_r <= 16'(counter_value_r + 16'h0001);
      end
   end

   // ---------------------------------------------------------------
   // Capture unit
   // ---------------------------------------------------------------
   capture_event_unit u_capture (
      .clock       (clock),
      .reset_n     (reset_n),
      .pin_level   (capture_pin_in),
      .mode        (capture_event_sel_r),
      .event_pulse (cap_event),
      .in_capture  (in_capture)
   );

   // Capture overwrites whatever is stored, read or not
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         capture_register_r <= timer_pkg::RST_COUNT;
      end else if (cap_event && in_capture) begin
         capture_register_r <= counter_value_r;
      end else begin
         if (hit(timer_pkg::OFS_CAPTURE_LOW)) begin
            capture_register_r[7:0] <= req.wdata;
         end
         if (hit(timer_pkg::OFS_CAPTURE_HIGH)) begin
            capture_register_r[15:8] <= req.wdata;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         capture_event_sel_r <= timer_pkg::MODE_OFF;
      end else if (hit(timer_pkg::OFS_CAPTURE_MODE)) begin
         capture_event_sel_r <= req.wdata[3:0];
      end
   end

   // ---------------------------------------------------------------
   // Control registers
   // ---------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         tcon_r             <= timer_pkg::RST_ZERO_BYTE;
         enables_r          <= timer_pkg::RST_ZERO_BYTE;
         irq_control_r      <= timer_pkg::RST_ZERO_BYTE;
         port_data_r        <= 3'h0;
         port_c_direction_r <= timer_pkg::RST_PORT_DIR;
      end else begin
         if (hit(timer_pkg::OFS_TIMER_CONTROL)) begin
            tcon_r <= req.wdata & timer_pkg::TCON_MASK;
         end
         if (hit(timer_pkg::OFS_IRQ_ENABLE)) begin
            enables_r <= req.wdata & timer_pkg::IRQ_BITS_MASK;
         end
         if (hit(timer_pkg::OFS_IRQ_CONTROL)) begin
            irq_control_r <= req.wdata;
         end
         if (hit(timer_pkg::OFS_PORT_DATA)) begin
            port_data_r <= req.wdata[2:0];
         end
         if (hit(timer_pkg::OFS_PORT_DIR)) begin
            port_c_direction_r <= req.wdata[2:0];
         end
      end
   end

   // Flags: a hardware set in the same cycle as a software clear wins
   assign flags_wr = req.wr && (req.addr == timer_pkg::OFS_IRQ_FLAGS);

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         flags_r <= timer_pkg::RST_ZERO_BYTE;
      end else begin
         flags_r <= (flags_wr ? (req.wdata & timer_pkg::IRQ_BITS_MASK) : flags_r)
                    | {5'h00, (cap_event && in_capture) || trigger, 1'b0, wrap};
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   // Interrupt needs flag, its enable and the global peripheral enable
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         irq_request <= 1'b0;
      end else begin
         irq_request <= irq_control_r[timer_pkg::BIT_GLOBAL_EN]
                        && |(flags_r & enables_r);
      end
   end

   // Oscillator enable overrides the direction bits of pins 1:0
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         low_power_osc_enable <= 1'b0;
         port_oe              <= 3'h0;
         port_out             <= 3'h0;
      end else begin
         low_power_osc_enable <= tcon_r.low_power_osc_enable;
         port_oe[2]           <= ~port_c_direction_r[2];
         port_oe[1:0]         <= tcon_r.low_power_osc_enable
                                 ? 2'h0 : ~port_c_direction_r[1:0];
         port_out             <= port_data_r;
      end
   end

   // Read mux; unmapped addresses read zero
   always_comb begin
      case (req.addr)
         timer_pkg::OFS_IRQ_CONTROL:   rdata_nxt = irq_control_r;
         timer_pkg::OFS_IRQ_FLAGS:     rdata_nxt = flags_r;
         timer_pkg::OFS_COUNT_LOW:     rdata_nxt = counter_value_r[7:0];
         timer_pkg::OFS_COUNT_HIGH:    rdata_nxt = counter_value_r[15:8];
         timer_pkg::OFS_TIMER_CONTROL: rdata_nxt = tcon_r;
         timer_pkg::OFS_CAPTURE_LOW:   rdata_nxt = capture_register_r[7:0];
         timer_pkg::OFS_CAPTURE_HIGH:  rdata_nxt = capture_register_r[15:8];
         timer_pkg::OFS_CAPTURE_MODE:  rdata_nxt = {4'h0, capture_event_sel_r};
         timer_pkg::OFS_PORT_DATA:     rdata_nxt = {5'h00, port_data_r};
         timer_pkg::OFS_PORT_DIR:      rdata_nxt = {5'h1F, port_c_direction_r};
         timer_pkg::OFS_IRQ_ENABLE:    rdata_nxt = enables_r;
         default:                      rdata_nxt = 8'h00;
      endcase
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         reg_rdata <= 8'h00;
      end else if (req.rd) begin
         reg_rdata <= rdata_nxt;
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   property p_wrap_flag;
      @(posedge clock) disable iff (!reset_n)
      wrap |=> flags_r[timer_pkg::BIT_OVERFLOW] && (counter_value_r == 16'h0000);
   endproperty
   a_wrap_flag: assert property (p_wrap_flag)
      else $error("Wrap did not clear counter and set overflow");

   property p_stopped;
      @(posedge clock) disable iff (!reset_n)
      !tcon_r.counter_run && !wr_low && !wr_high && !trigger |=> $stable(counter_value_r);
   endproperty
   a_stopped: assert property (p_stopped)
      else $error("Counter moved while stopped");

   property p_instr_count;
      @(posedge clock) disable iff (!reset_n)
      instr_tick && tcon_r.counter_run && !tcon_r.clock_source_sel
      && tcon_r.prescale_sel == 2'h0 && pre_cnt_r == 3'h0
      && !wr_low && !wr_high && !trigger
      |=> counter_value_r == 16'($past(counter_value_r) + 16'h0001);
   endproperty
   a_instr_count: assert property (p_instr_count)
      else $error("Timer mode did not count the instruction cycle");

   property p_sync_source;
      @(posedge clock) disable iff (!reset_n)
      count_tick && tcon_r.clock_source_sel
      |-> (tcon_r.ext_sync_bypass ? raw_edge : sync_edge);
   endproperty
   a_sync_source: assert property (p_sync_source)
      else $error("External tick from the wrong path");

   property p_osc_pins;
      @(posedge clock) disable iff (!reset_n)
      tcon_r.low_power_osc_enable |=> port_oe[1:0] == 2'h0;
   endproperty
   a_osc_pins: assert property (p_osc_pins)
      else $error("Oscillator pins driven while oscillator on");

   property p_trigger_clear;
      @(posedge clock) disable iff (!reset_n)
      trigger && !wr_low && !wr_high |=> counter_value_r == 16'h0000;
   endproperty
   a_trigger_clear: assert property (p_trigger_clear)
      else $error("Trigger did not clear counter");

   property p_capture_copy;
      @(posedge clock) disable iff (!reset_n)
      cap_event && in_capture |=> capture_register_r == $past(counter_value_r)
                                  && flags_r[timer_pkg::BIT_CAPTURE];
   endproperty
   a_capture_copy: assert property (p_capture_copy)
      else $error("Capture did not copy counter or set flag");

   property p_flag_sticky;
      @(posedge clock) disable iff (!reset_n)
      flags_r[timer_pkg::BIT_CAPTURE] && !flags_wr |=> flags_r[timer_pkg::BIT_CAPTURE];
   endproperty
   a_flag_sticky: assert property (p_flag_sticky)
      else $error("Capture flag cleared by hardware");

   property p_enable_read;
      @(posedge clock) disable iff (!reset_n)
      req.rd && req.addr == timer_pkg::OFS_IRQ_ENABLE
      |=> reg_rdata[7] == 1'b0 && reg_rdata[5:4] == 2'h0;
   endproperty
   a_enable_read: assert property (p_enable_read)
      else $error("Unimplemented enable bits read nonzero");

   property p_irq;
      @(posedge clock) disable iff (!reset_n)
      flags_r[0] && enables_r[0] && irq_control_r[timer_pkg::BIT_GLOBAL_EN] |=> irq_request;
   endproperty
   a_irq: assert property (p_irq)
      else $error("Enabled overflow flag raised no interrupt");

endmodule : timer16_with_capture

/* File: test/pin_source_model.sv */
// Far-side model: external count clock and capture pin source
`timescale 1ns/1ps
module pin_source_model (
   input  wire logic       clock,
   input  wire logic       start,
   input  wire logic [7:0] burst,
   input  wire logic       cap_toggle,
   output logic            ext_clock_in,
   output logic            capture_pin_in
);
   logic [7:0] left_r;
   logic [2:0] phase_r;

   // Burst of slow pulses; the line rests low between bursts
   always_ff @(posedge clock) begin
      if (start) begin
         left_r  <= burst;
         phase_r <= 3'h0;
      end else if (left_r != 8'h00) begin
         phase_r <= phase_r + 3'h1;
         if (phase_r == 3'h7) left_r <= left_r - 8'h01;
      end
   end

   // Eight-cycle period keeps edges clear of the two-flop synchroniser
   assign ext_clock_in = (left_r != 8'h00) && phase_r[2];

   // Capture pin flips once per request
   always_ff @(posedge clock) begin
      if (start && burst == 8'h00) capture_pin_in <= 1'b0;
      else if (cap_toggle) capture_pin_in <= ~capture_pin_in;
   end
endmodule : pin_source_model

/* File: test/timer16_with_capture_tb_top.sv */
// Self-checking bench for the timer with capture
`timescale 1ns/1ps
module timer16_with_capture_tb_top;
   logic clock = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, irq_request;
   logic start = 1, cap_toggle = 0, ext_clock_in, capture_pin_in, low_power_osc_enable;
   logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, burst = 0, v, w;
   logic [2:0] port_out, port_oe;
   int num_errors = 0, tests_run = 0;

   always #20 clock = ~clock;

   timer16_with_capture DUT (.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .irq_request(irq_request), .ext_clock_in(ext_clock_in),
      .capture_pin_in(capture_pin_in), .port_out(port_out), .port_oe(port_oe),
      .low_power_osc_enable(low_power_osc_enable));
   pin_source_model P (.clock(clock), .start(start), .burst(burst),
      .cap_toggle(cap_toggle), .ext_clock_in(ext_clock_in),
      .capture_pin_in(capture_pin_in));

   task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
      tests_run++;
      if (s !== e) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clock);
      reg_addr <= a; reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd
   task automatic wt(input int n);
      repeat (n) @(posedge clock);
   endtask : wt
   task automatic cnt(input logic [15:0] c);
      wr(timer_pkg::OFS_COUNT_LOW, c[7:0]);
      wr(timer_pkg::OFS_COUNT_HIGH, c[15:8]);
   endtask : cnt
   task automatic tog(input int n);
      repeat (n) begin
         @(posedge clock) cap_toggle <= 1'b1;
         @(posedge clock) cap_toggle <= 1'b0;
         wt(4);
      end
   endtask : tog
   task automatic cap_is(input logic [15:0] e);
      rd(timer_pkg::OFS_CAPTURE_LOW, v);
      rd(timer_pkg::OFS_CAPTURE_HIGH, w);
      chk("capture", {w, v}, e);
   endtask : cap_is

   // Reset values, reserved enable bits, unmapped place
   task automatic t_regs();
      rd(timer_pkg::OFS_IRQ_FLAGS, v); chk("flags", v, 0);
      rd(timer_pkg::OFS_IRQ_ENABLE, v); chk("enable", v, 0);
      rd(timer_pkg::OFS_CAPTURE_MODE, v); chk("mode", v, 0);
      wr(timer_pkg::OFS_IRQ_ENABLE, 8'hFF);
      rd(timer_pkg::OFS_IRQ_ENABLE, v); chk("enable", v, 16'h004F);
      wt(1); #1 chk("rdata idle", reg_rdata, 0);
      rd(8'h3A, v); chk("unmapped", v, 0);
      wr(timer_pkg::OFS_IRQ_ENABLE, 8'h00);
   endtask : t_regs

   // Timer mode at each prescale: 256 clocks give 64 ticks divided down
   task automatic t_prescale();
      for (int c = 0; c < 4; c++) begin
         cnt(16'h0000);
         wr(timer_pkg::OFS_TIMER_CONTROL, 8'(c << 4) | 8'h01);
         wt(255);
         wr(timer_pkg::OFS_TIMER_CONTROL, 8'h00);
         rd(timer_pkg::OFS_COUNT_LOW, v);
         chk("ticks", 16'(v >= (64 >> c) - 1 && v <= (64 >> c) + 1), 1);
      end
   endtask : t_prescale

   // Wrap sets the flag, request follows flag and global bit with the enable set
   task automatic t_overflow();
      cnt(16'hFFFE);
      wr(timer_pkg::OFS_IRQ_ENABLE, 8'h01);
      wr(timer_pkg::OFS_IRQ_CONTROL, 8'h40);
      wr(timer_pkg::OFS_TIMER_CONTROL, 8'h01);
      wt(12);
      wr(timer_pkg::OFS_TIMER_CONTROL, 8'h00);
      rd(timer_pkg::OFS_IRQ_FLAGS, v); chk("ovf", v, 16'h0001);
      rd(timer_pkg::OFS_COUNT_HIGH, v); chk("wrapped", v, 0);
      chk("irq", irq_request, 1);
      wr(timer_pkg::OFS_IRQ_CONTROL, 8'h00); wt(2);
      chk("irq global", irq_request, 0);
      wr(timer_pkg::OFS_IRQ_CONTROL, 8'h40); wt(2);
      chk("irq again", irq_request, 1);
      wr(timer_pkg::OFS_IRQ_FLAGS, 8'h00); wt(2);
      chk("irq clr", irq_request, 0);
   endtask : t_overflow

   // Counter mode, synchronised then bypassed: five edges each
   task automatic t_extern(input logic [7:0] tc);
      cnt(16'h0000);
      wr(timer_pkg::OFS_TIMER_CONTROL, tc);
      @(posedge clock) begin start <= 1'b1; burst <= 8'd5; end
      @(posedge clock) start <= 1'b0;
      wt(50);
      wr(timer_pkg::OFS_TIMER_CONTROL, 8'h00);
      rd(timer_pkg::OFS_COUNT_LOW, v); chk("edges", v, 16'd5);
   endtask : t_extern

   // Oscillator takes pins 1:0 away from the direction bits
   task automatic t_osc();
      wr(timer_pkg::OFS_PORT_DATA, 8'h05);
      wr(timer_pkg::OFS_PORT_DIR, 8'h00); wt(2);
      chk("oe", port_oe, 3'b111);
      chk("out", port_out, 3'b101);
      wr(timer_pkg::OFS_TIMER_CONTROL, 8'h08); wt(2);
      chk("oe osc", port_oe, 3'b100);
      chk("osc", low_power_osc_enable, 1);
      wr(timer_pkg::OFS_TIMER_CONTROL, 8'h00);
   endtask : t_osc

   // Capture edges with the pin driven as output, overwrite, every 4th
   task automatic t_capture();
      cnt(16'h1234);
      wr(timer_pkg::OFS_CAPTURE_MODE, timer_pkg::MODE_RISE);
      wr(timer_pkg::OFS_IRQ_FLAGS, 8'h00);
      tog(1); cap_is(16'h1234);
      rd(timer_pkg::OFS_IRQ_FLAGS, v); chk("capflag", v, 16'h0004);
      cnt(16'h5678); tog(2); cap_is(16'h5678);
      wr(timer_pkg::OFS_CAPTURE_MODE, timer_pkg::MODE_FALL);
      cnt(16'h0ABC); tog(1); cap_is(16'h0ABC);
      wr(timer_pkg::OFS_CAPTURE_MODE, timer_pkg::MODE_OFF);
      wr(timer_pkg::OFS_CAPTURE_MODE, timer_pkg::MODE_RISE4);
      wr(timer_pkg::OFS_IRQ_FLAGS, 8'h00); cnt(16'h0011);
      tog(6); rd(timer_pkg::OFS_IRQ_FLAGS, v); chk("rise3", v, 0);
      tog(1); rd(timer_pkg::OFS_IRQ_FLAGS, v); chk("rise4", v, 16'h0004);
      cap_is(16'h0011);
      wr(timer_pkg::OFS_CAPTURE_MODE, timer_pkg::MODE_OFF);
      wr(timer_pkg::OFS_CAPTURE_MODE, timer_pkg::MODE_RISE16);
      wr(timer_pkg::OFS_IRQ_FLAGS, 8'h00); cnt(16'h0022);
      tog(31); rd(timer_pkg::OFS_IRQ_FLAGS, v); chk("rise15", v, 0);
      tog(1); rd(timer_pkg::OFS_IRQ_FLAGS, v); chk("rise16", v, 16'h0004);
      cap_is(16'h0022);
   endtask : t_capture

   // Compare trigger clears the running counter
   task automatic t_trigger();
      wr(timer_pkg::OFS_CAPTURE_MODE, timer_pkg::MODE_OFF);
      cnt(16'h0000);
      wr(timer_pkg::OFS_CAPTURE_LOW, 8'h05); wr(timer_pkg::OFS_CAPTURE_HIGH, 8'h00);
      wr(timer_pkg::OFS_CAPTURE_MODE, timer_pkg::MODE_TRIGGER);
      wr(timer_pkg::OFS_TIMER_CONTROL, 8'h01); wt(60);
      wr(timer_pkg::OFS_TIMER_CONTROL, 8'h00);
      rd(timer_pkg::OFS_COUNT_LOW, v); chk("cleared", 16'(v < 8'd5), 1);
   endtask : t_trigger

   task automatic tally_and_finish();
      if (num_errors == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : tally_and_finish

   // Watchdog well beyond the roughly 1700 cycles of the sequence
   initial begin
      #(40 * 20000);
      num_errors++;
      tally_and_finish();
   end

   // Main sequence
   initial begin
      wt(20);
      reset_n <= 1'b1; start <= 1'b0;
      t_regs(); t_prescale(); t_overflow();
      t_extern(8'h03); t_extern(8'h07);
      t_osc(); t_capture(); t_trigger();
      tally_and_finish();
   end
endmodule : timer16_with_capture_tb_top
